// ==== pocs_pkg.sv ====
// Package: register map, field layout and carriers for port op control/status
package pocs_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_OP_CTRL     = 12'h020;
   localparam logic [11:0] OFF_LINK_STATE  = 12'h030;
   localparam logic [11:0] OFF_MAC_IF_CTRL0 = 12'h040;
   localparam logic [11:0] OFF_MAC_IF_CTRL1 = 12'h044;
   localparam logic [11:0] OFF_PHY_LINK    = 12'h048;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int TAIL_TAG_BIT   = 2;
   localparam int QSPLIT_LSB     = 0;
   localparam int CTRL1_SPD_BIT  = 6;
   localparam int CTRL0_SPD_BIT  = 4;
   localparam int CTRL0_DPX_BIT  = 6;
   localparam int CTRL0_TXFC_BIT = 5;
   localparam int CTRL0_RXFC_BIT = 3;
   localparam int ST_SPD_LSB     = 3;
   localparam int ST_DPX_BIT     = 2;
   localparam int ST_TXFC_BIT    = 1;
   localparam int ST_RXFC_BIT    = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_OP_CTRL   = 8'h00;
   localparam logic [7:0] RST_MAC_CTRL0 = 8'h40;
   localparam logic [7:0] RST_MAC_CTRL1 = 8'h00;
   localparam logic [7:0] RST_STATUS    = 8'h04;
   localparam logic [7:0] OP_CTRL_MASK  = 8'hc7;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      POCS_Q_SINGLE = 2'b00,
      POCS_Q_TWO    = 2'b01,
      POCS_Q_FOUR   = 2'b10,
      POCS_Q_RSVD   = 2'b11
   } pocs_qsplit_t;

   typedef enum logic [1:0] {
      POCS_SPD_10   = 2'b00,
      POCS_SPD_100  = 2'b01,
      POCS_SPD_1000 = 2'b10
   } pocs_speed_t;

   // Negotiated link result from the PHY
   typedef struct packed {
      logic [1:0] speed;
      logic       full_duplex;
      logic       link_up;
      logic       tx_pause_neg;
      logic       rx_pause_neg;
   } pocs_phy_link_t;

   // Egress configuration towards the queue manager
   typedef struct packed {
      logic       tail_tag;
      logic [2:0] queue_count;
      logic       prio_sort;
   } pocs_egress_cfg_t;

endpackage

// ==== pocs_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous levels
module pocs_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,    // Clock
   input  wire logic         presetn, // Async reset, low
   input  wire logic [W-1:0] din,     // Asynchronous level
   output logic      [W-1:0] dout     // Synchronised level
);

   logic [W-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// ==== pocs_status_mux.sv ====
// Status byte composer: PHY link result or mirrored MAC interface settings
module pocs_status_mux (
   input  wire logic                    is_phy,    // Port has an internal PHY
   input  wire pocs_pkg::pocs_phy_link_t link,      // Synchronised link result
   input  wire logic [1:0]              pause_adv, // Advertised pause bits
   input  wire logic [7:0]              ctrl0,     // MAC interface control 0
   input  wire logic [7:0]              ctrl1,     // MAC interface control 1
   output logic      [7:0]              status     // Composed status byte
);

   logic fc_ok;

   always_comb begin
      status = 8'h00;
      fc_ok  = (pause_adv != 2'b00) && link.link_up;
      if (is_phy) begin
         status[pocs_pkg::ST_SPD_LSB +: 2] = link.speed;
         status[pocs_pkg::ST_DPX_BIT]      = link.full_duplex;
         status[pocs_pkg::ST_TXFC_BIT]     = fc_ok && link.tx_pause_neg;
         status[pocs_pkg::ST_RXFC_BIT]     = fc_ok && link.rx_pause_neg;
      end else begin
         status[pocs_pkg::ST_SPD_LSB + 1] = ctrl1[pocs_pkg::CTRL1_SPD_BIT];
         status[pocs_pkg::ST_SPD_LSB]     = ctrl0[pocs_pkg::CTRL0_SPD_BIT];
         status[pocs_pkg::ST_DPX_BIT]     = ctrl0[pocs_pkg::CTRL0_DPX_BIT];
         status[pocs_pkg::ST_TXFC_BIT]    = ctrl0[pocs_pkg::CTRL0_TXFC_BIT];
         status[pocs_pkg::ST_RXFC_BIT]    = ctrl0[pocs_pkg::CTRL0_RXFC_BIT];
      end
   end

endmodule

// ==== pocs_port.sv ====
// Per-port operation control and status register bank on APB
// Notes on behaviour
// - Tail tag bit one makes host port
// - Split 00 gives one unsorted queue
// - Split 01 gives two priority queues
// - Split 10 four queues; 11 reserved
// - PHY port speed reports negotiated link
// - Non-PHY speed mirrors MAC control bits
// - Non-PHY duplex mirrors control0 bit 6
// - PHY duplex reports link, one full
// - Non-PHY tx pause mirrors control0 bit5
// - Non-PHY rx pause mirrors control0 bit3
// - PHY pause needs advert, link, negotiation
module pocs_port (
   input  wire logic                       pclk,        // 200 MHz clock
   input  wire logic                       presetn,     // Async reset, low
   input  wire logic                       psel,        // APB select
   input  wire logic                       penable,     // APB access phase
   input  wire logic                       pwrite,      // APB write
   input  wire logic [11:0]                paddr,       // APB byte address
   input  wire logic [31:0]                pwdata,      // APB write data
   output logic      [31:0]                prdata,      // APB read data
   output logic                            pready,      // APB ready
   output logic                            pslverr,     // APB error
   input  wire logic                       is_phy,      // Port has a PHY
   input  wire pocs_pkg::pocs_phy_link_t   phy_link,    // Async link result
   input  wire logic [1:0]                 pause_adv,   // Advertised pause
   output pocs_pkg::pocs_egress_cfg_t      egress_cfg,  // Egress setup
   output logic                            cfg_reserved // Split set to 11
);

   // ---------------------------------------------------------------
   // Registers and decode
   // ---------------------------------------------------------------
   logic [7:0]               op_ctrl;
   logic [7:0]               mac_if_ctrl0;
   logic [7:0]               mac_if_ctrl1;
   logic [7:0]               port_link_state;
   logic [7:0]               next_status;
   pocs_pkg::pocs_phy_link_t link_s;
   logic                     setup;
   logic                     wr_en;
   logic                     known;
   pocs_pkg::pocs_qsplit_t   qs;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   assign setup = psel && !penable;
   assign wr_en = setup && pwrite;
   assign known = hit(paddr, pocs_pkg::OFF_OP_CTRL)
               || hit(paddr, pocs_pkg::OFF_LINK_STATE)
               || hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL0)
               || hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL1)
               || hit(paddr, pocs_pkg::OFF_PHY_LINK);

   // ---------------------------------------------------------------
   // Synchronise the PHY result, compose status
   // ---------------------------------------------------------------
   pocs_sync #(.W($bits(pocs_pkg::pocs_phy_link_t))) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (phy_link),
      .dout    (link_s)
   );

   pocs_status_mux u_mux (
      .is_phy    (is_phy),
      .link      (link_s),
      .pause_adv (pause_adv),
      .ctrl0     (mac_if_ctrl0),
      .ctrl1     (mac_if_ctrl1),
      .status    (next_status)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_link_state <= pocs_pkg::RST_STATUS;
      end else begin
         port_link_state <= next_status;
      end
   end

   // ---------------------------------------------------------------
   // Writable registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_ctrl <= pocs_pkg::RST_OP_CTRL;
      end else if (wr_en && hit(paddr, pocs_pkg::OFF_OP_CTRL)) begin
         op_ctrl <= pwdata[7:0] & pocs_pkg::OP_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac_if_ctrl0 <= pocs_pkg::RST_MAC_CTRL0;
         mac_if_ctrl1 <= pocs_pkg::RST_MAC_CTRL1;
      end else if (wr_en) begin
         if (hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL0)) begin
            mac_if_ctrl0 <= pwdata[7:0];
         end
         if (hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL1)) begin
            mac_if_ctrl1 <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // APB answer: ready in the first access cycle
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !known;
         prdata  <= 32'h0000_0000;
         if (setup && !pwrite) begin
            // Reading status only samples it
            unique case (1'b1)
               hit(paddr, pocs_pkg::OFF_OP_CTRL):
                  prdata[7:0] <= op_ctrl;
               hit(paddr, pocs_pkg::OFF_LINK_STATE):
                  prdata[7:0] <= port_link_state;
               hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL0):
                  prdata[7:0] <= mac_if_ctrl0;
               hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL1):
                  prdata[7:0] <= mac_if_ctrl1;
               hit(paddr, pocs_pkg::OFF_PHY_LINK):
                  prdata[5:0] <= link_s;
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Egress configuration outputs
   // ---------------------------------------------------------------
   assign qs = pocs_pkg::pocs_qsplit_t'(op_ctrl[pocs_pkg::QSPLIT_LSB +: 2]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         egress_cfg   <= '{tail_tag: 1'b0, queue_count: 3'h1,
                           prio_sort: 1'b0};
         cfg_reserved <= 1'b0;
      end else begin
         egress_cfg.tail_tag <= op_ctrl[pocs_pkg::TAIL_TAG_BIT];
         cfg_reserved        <= (qs == pocs_pkg::POCS_Q_RSVD);
         unique case (qs)
            pocs_pkg::POCS_Q_SINGLE: begin
               egress_cfg.queue_count <= 3'h1;
               egress_cfg.prio_sort   <= 1'b0;
            end
            pocs_pkg::POCS_Q_TWO: begin
               egress_cfg.queue_count <= 3'h2;
               egress_cfg.prio_sort   <= 1'b1;
            end
            pocs_pkg::POCS_Q_FOUR: begin
               egress_cfg.queue_count <= 3'h4;
               egress_cfg.prio_sort   <= 1'b1;
            end
            pocs_pkg::POCS_Q_RSVD: begin
               egress_cfg.queue_count <= 3'h1;
               egress_cfg.prio_sort   <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence tt_write_s;
      wr_en && hit(paddr, pocs_pkg::OFF_OP_CTRL);
   endsequence

   tail_tag_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      tt_write_s |-> ##2 egress_cfg.tail_tag == $past(pwdata[2], 2))
      else $error("tail tag output does not follow write");

   single_q_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (qs == pocs_pkg::POCS_Q_SINGLE) |=>
      (egress_cfg.queue_count == 3'h1 && !egress_cfg.prio_sort))
      else $error("split 00 not single queue");

   two_q_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (qs == pocs_pkg::POCS_Q_TWO) |=>
      (egress_cfg.queue_count == 3'h2 && egress_cfg.prio_sort))
      else $error("split 01 not two queues");

   four_q_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (qs == pocs_pkg::POCS_Q_FOUR) |=>
      (egress_cfg.queue_count == 3'h4 && !cfg_reserved))
      else $error("split 10 not four queues");

   phy_speed_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      is_phy |=> port_link_state[4:3] == $past(link_s.speed))
      else $error("phy speed not reported");

   mac_speed_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !is_phy |=> port_link_state[4:3] ==
         {$past(mac_if_ctrl1[6]), $past(mac_if_ctrl0[4])})
      else $error("mac speed not mirrored");

   mac_duplex_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !is_phy |=> port_link_state[2] == $past(mac_if_ctrl0[6]))
      else $error("mac duplex not mirrored");

   phy_duplex_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      is_phy |=> port_link_state[2] == $past(link_s.full_duplex))
      else $error("phy duplex not reported");

   mac_pause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !is_phy |=> port_link_state[1:0] ==
         {$past(mac_if_ctrl0[5]), $past(mac_if_ctrl0[3])})
      else $error("mac pause not mirrored");

   phy_pause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (is_phy && (!link_s.link_up || pause_adv == 2'b00)) |=>
      port_link_state[1:0] == 2'b00)
      else $error("phy pause set without negotiation");

   ro_status_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && pwrite && hit(paddr, pocs_pkg::OFF_LINK_STATE))
      |=> pready && !pslverr && $stable(op_ctrl) && $stable(mac_if_ctrl0))
      else $error("status write disturbed registers");

   apb_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("pready not single cycle");

   // ---------------------------------------------------------------
   // Further checks: decode, read path, synchroniser
   // ---------------------------------------------------------------
   sequence rd_status_s;
      setup && !pwrite && hit(paddr, pocs_pkg::OFF_LINK_STATE);
   endsequence

   sequence rd_op_s;
      setup && !pwrite && hit(paddr, pocs_pkg::OFF_OP_CTRL);
   endsequence

   sequence wr_ctrl0_s;
      setup && pwrite && hit(paddr, pocs_pkg::OFF_MAC_IF_CTRL0);
   endsequence

   mac_rx_pause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !is_phy |=> port_link_state[pocs_pkg::ST_RXFC_BIT] ==
         $past(mac_if_ctrl0[pocs_pkg::CTRL0_RXFC_BIT]))
      else $error("mac rx pause not mirrored");

   phy_pause_on_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (is_phy && link_s.link_up && pause_adv != 2'b00) |=>
      port_link_state[1:0] ==
         {$past(link_s.tx_pause_neg), $past(link_s.rx_pause_neg)})
      else $error("phy pause not reported");

   rsvd_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (qs == pocs_pkg::POCS_Q_RSVD) |=>
      (cfg_reserved && egress_cfg.queue_count == 3'h1))
      else $error("split 11 not flagged");

   tail_tag_follow_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> egress_cfg.tail_tag ==
         $past(op_ctrl[pocs_pkg::TAIL_TAG_BIT]))
      else $error("tail tag output does not track control");

   op_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && hit(paddr, pocs_pkg::OFF_OP_CTRL)) |=> $stable(op_ctrl))
      else $error("control changed without a write");

   queue_legal_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      egress_cfg.queue_count inside {3'h1, 3'h2, 3'h4})
      else $error("illegal queue count");

   status_rsvd_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      port_link_state[7:5] == 3'b000)
      else $error("status reserved bits set");

   status_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_status_s |=> pready &&
         prdata == {24'h00_0000, $past(port_link_state)})
      else $error("status read data wrong");

   op_readback_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_op_s |=> pready && prdata == {24'h00_0000, $past(op_ctrl)})
      else $error("control read data wrong");

   ctrl0_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl0_s |=> mac_if_ctrl0 == $past(pwdata[7:0]))
      else $error("control 0 write lost");

   unmapped_err_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !known) |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   mapped_ok_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && known) |=> pready && !pslverr)
      else $error("mapped access refused");

   unmapped_drop_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && pwrite && !known) |=> $stable(op_ctrl) &&
         $stable(mac_if_ctrl0) && $stable(mac_if_ctrl1))
      else $error("unmapped write changed a register");

   idle_rdata_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == 32'h0000_0000 && !pslverr))
      else $error("read data or error outside access");

   sync_delay_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(presetn, 2) |-> link_s == $past(phy_link, 2))
      else $error("link result not two stages late");

endmodule

// ==== pocs_port_bench.sv ====
// Self-checking bench for the port operation control and status bank
module pocs_port_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                       pclk = 1'b0;
   logic                       presetn = 1'b0;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic [11:0]                paddr = 12'h000;
   logic [31:0]                pwdata = 32'h00000000;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic                       is_phy = 1'b0;
   pocs_pkg::pocs_phy_link_t   phy_link = '0;
   logic [1:0]                 pause_adv = 2'h0;
   pocs_pkg::pocs_egress_cfg_t egress_cfg;
   logic                       cfg_reserved;
   int                         n_errors = 0;
   int                         checked = 0;
   int                         cycles = 0;
   logic [31:0]                seed = 32'h000061cf;
   logic [31:0]                rd;
   logic                       er;
   logic [7:0]                 op;
   logic [7:0]                 c0;
   logic [7:0]                 c1;
   logic [5:0]                 lk;
   logic [1:0]                 adv;

   pocs_port DUT (
      .pclk         (pclk),
      .presetn      (presetn),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .is_phy       (is_phy),
      .phy_link     (phy_link),
      .pause_adv    (pause_adv),
      .egress_cfg   (egress_cfg),
      .cfg_reserved (cfg_reserved)
   );

   always #2.5 pclk = ~pclk;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   function automatic logic [4:0] exp_egress(input logic [7:0] o);
      logic [2:0] qc;
      qc = (o[1:0] == 2'b01) ? 3'h2 : ((o[1:0] == 2'b10) ? 3'h4 : 3'h1);
      return {o[2], qc, (o[1:0] == 2'b01) || (o[1:0] == 2'b10)};
   endfunction

   function automatic logic [7:0] exp_mac(input logic [7:0] a,
                                          input logic [7:0] b);
      return {3'h0, b[6], a[4], a[6], a[5], a[3]};
   endfunction

   function automatic logic [7:0] exp_phy(input logic [5:0] l,
                                          input logic [1:0] adv);
      logic ok;
      ok = l[2] && (adv != 2'h0);
      return {3'h0, l[5:4], l[3], ok && l[1], ok && l[0]};
   endfunction

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      check({27'h0, egress_cfg}, 32'h00000002, "egress reset");
      apb(1'b0, pocs_pkg::OFF_OP_CTRL, 32'h0);
      check(rd, 32'h00000000, "op reset");
      apb(1'b0, pocs_pkg::OFF_MAC_IF_CTRL0, 32'h0);
      check(rd, 32'h00000040, "ctrl0 reset");
      apb(1'b0, pocs_pkg::OFF_MAC_IF_CTRL1, 32'h0);
      check(rd, 32'h00000000, "ctrl1 reset");
      apb(1'b0, pocs_pkg::OFF_LINK_STATE, 32'h0);
      check(rd, 32'h00000004, "status reset");
      // Every tail tag and split setting, junk in the other bits
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         op = (seed[7:0] & 8'hf8) | 8'(i);
         apb(1'b1, pocs_pkg::OFF_OP_CTRL, {seed[31:8], op});
         // Egress setup follows the register one edge later
         @(posedge pclk);
         check({27'h0, egress_cfg}, 32'(exp_egress(op)), "eg");
         check({31'h0, cfg_reserved}, {31'h0, op[1:0] == 2'b11}, "rsvd");
         apb(1'b0, pocs_pkg::OFF_OP_CTRL, 32'h0);
         check(rd, {24'h0, op & 8'hc7}, "op readback");
      end
      // Status is read-only; unmapped address errors
      apb(1'b1, pocs_pkg::OFF_LINK_STATE, 32'h000000fb);
      check({31'h0, er}, 32'h0, "status write err");
      apb(1'b0, pocs_pkg::OFF_LINK_STATE, 32'h0);
      check(rd, 32'h00000004, "status after write");
      apb(1'b1, 12'h100, 32'h000000ff);
      check({31'h0, er}, 32'h1, "unmapped write err");
      apb(1'b0, 12'h100, 32'h0);
      check(rd, 32'h0, "unmapped read");
      check({31'h0, er}, 32'h1, "unmapped read err");
      // Non-PHY port mirrors the MAC interface control bits
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         c0 = seed[7:0];
         c1 = seed[15:8];
         apb(1'b1, pocs_pkg::OFF_MAC_IF_CTRL0, {24'h0, c0});
         apb(1'b1, pocs_pkg::OFF_MAC_IF_CTRL1, {24'h0, c1});
         apb(1'b0, pocs_pkg::OFF_MAC_IF_CTRL0, 32'h0);
         check(rd, {24'h0, c0}, "ctrl0 readback");
         repeat (2) @(posedge pclk);
         apb(1'b0, pocs_pkg::OFF_LINK_STATE, 32'h0);
         check(rd, {24'h0, exp_mac(c0, c1)}, "mac status");
         apb(1'b0, pocs_pkg::OFF_LINK_STATE, 32'h0);
         check(rd, {24'h0, exp_mac(c0, c1)}, "status reread");
      end
      // PHY port reports the negotiated link
      is_phy <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         lk = seed[5:0];
         if (lk[5:4] == 2'b11) begin
            lk[5:4] = 2'b10;
         end
         adv = seed[9:8];
         if (i == 0) begin
            lk = 6'h2b;
            adv = 2'h3;
         end else if (i == 1) begin
            lk = 6'h1f;
            adv = 2'h0;
         end else if (i == 2) begin
            lk = 6'h27;
            adv = 2'h1;
         end
         pause_adv <= adv;
         phy_link <= lk;
         repeat (5) @(posedge pclk);
         apb(1'b0, pocs_pkg::OFF_LINK_STATE, 32'h0);
         check(rd, {24'h0, exp_phy(lk, adv)}, "phy status");
         apb(1'b0, pocs_pkg::OFF_PHY_LINK, 32'h0);
         check(rd, {26'h0, lk}, "phy link readback");
      end
      print_verdict();
   end
endmodule
